// File: rtl/dmtr_pkg.sv
// dmtr_pkg: constants and carrier types for the modulator tuning register bank.
// assumes an I2C control port elsewhere decodes transfers into one-cycle
// register read and write strobes on clk_sys_in.
// How it works
// - bit 7 of 0x12 zeroes the left primary a0 coefficient when set, reset 0.
// - bits 6, 5, 4 of 0x12 zero the left primary b1, b2, b3 coefficients, reset 0.
// - bits 3 to 0 of 0x12 zero the right primary a0, b1, b2, b3 coefficients, reset 0.
// - bits 7 to 4 of 0x14 zero the left secondary a0, b1, b2, b3 coefficients, reset 0.
// - bits 3 to 0 of 0x14 zero the right secondary a0, b1, b2, b3 coefficients, reset 0.
// - bit 7 of 0x13 selects the left primary local loop gain, reset 0.
// - bit 5 of 0x13 selects the left primary upper bit count, reset 0.
// - bit 3 of 0x13 selects the right primary local loop gain, reset 0.
// - bit 1 of 0x13 selects the right primary upper bit count, reset 0.
// - bit 7 of 0x15 selects the left secondary local loop gain, reset 0.
// - bit 5 of 0x15 selects the left secondary upper bit count, reset 0.
// - bit 3 of 0x15 selects the right secondary local loop gain, reset 0.
// - bit 1 of 0x15 selects the right secondary upper bit count, reset 0.
// - 0x16 holds a two-bit supply detector hysteresis in bits 1-0 resetting to 1, upper bits 0.
package dmtr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 5;

  localparam logic [ADDR_W-1:0] PRI_COEFF_ZERO_OFS = 8'h12;
  localparam logic [ADDR_W-1:0] PRI_LOOP_GAIN_OFS  = 8'h13;
  localparam logic [ADDR_W-1:0] SEC_COEFF_ZERO_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] SEC_LOOP_GAIN_OFS  = 8'h15;
  localparam logic [ADDR_W-1:0] NEG_HYST_OFS       = 8'h16;

  localparam logic [DATA_W-1:0] PRI_COEFF_ZERO_RST = 8'h00;
  localparam logic [DATA_W-1:0] PRI_LOOP_GAIN_RST  = 8'h00;
  localparam logic [DATA_W-1:0] SEC_COEFF_ZERO_RST = 8'h00;
  localparam logic [DATA_W-1:0] SEC_LOOP_GAIN_RST  = 8'h00;
  localparam logic [DATA_W-1:0] NEG_HYST_RST       = 8'h01;
  localparam logic [DATA_W-1:0] UNMAPPED_READ      = 8'h00;

  // field positions
  localparam int unsigned LEFT_A0_BIT  = 7;
  localparam int unsigned LEFT_B1_BIT  = 6;
  localparam int unsigned LEFT_B2_BIT  = 5;
  localparam int unsigned LEFT_B3_BIT  = 4;
  localparam int unsigned RIGHT_A0_BIT = 3;
  localparam int unsigned RIGHT_B1_BIT = 2;
  localparam int unsigned RIGHT_B2_BIT = 1;
  localparam int unsigned RIGHT_B3_BIT = 0;
  localparam int unsigned LEFT_GAIN_BIT  = 7;
  localparam int unsigned LEFT_UPPER_BIT = 5;
  localparam int unsigned RIGHT_GAIN_BIT = 3;
  localparam int unsigned RIGHT_UPPER_BIT = 1;
  localparam int unsigned HYST_LSB = 0;
  localparam int unsigned HYST_MSB = 1;

  // register write strobe from the control port
  typedef struct packed {
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmtr_wr_s;

  // per-modulator tuning, as seen by one modulator
  typedef struct packed {
    logic a0_zero;
    logic b1_zero;
    logic b2_zero;
    logic b3_zero;
    logic loop_gain;
    logic upper_bits;
  } dmtr_mod_s;

  // all four modulators plus the detector hysteresis
  typedef struct packed {
    dmtr_mod_s left_pri;
    dmtr_mod_s right_pri;
    dmtr_mod_s left_sec;
    dmtr_mod_s right_sec;
    logic [1:0] neg_detect_hysteresis;
  } dmtr_tune_s;

endpackage : dmtr_pkg

// File: rtl/dmtr_reg8.sv
// dmtr_reg8: one 8-bit read/write register with its own reset value.
// assumes write strobe and decode come from the same clock domain.
`timescale 1ns/1ns
module dmtr_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // write side
  input  wire logic       wr_sel_in,
  input  wire logic [7:0] wdata_in,
  // stored value
  output logic      [7:0] q_out
);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q_out <= RST_VAL;
    end else if (wr_sel_in) begin
      // reserved bits are stored as written too
      q_out <= wdata_in;
    end
  end

endmodule : dmtr_reg8

// File: rtl/dmtr_tune_hold.sv
// dmtr_tune_hold: holds the tuning word seen by the modulators.
// assumes sample_strobe_in is a one-cycle pulse on clk_sys_in that marks
// the start of each modulator sample.
`timescale 1ns/1ns
module dmtr_tune_hold (
  // clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  // update control
  input  wire logic                 sample_strobe_in,
  input  wire dmtr_pkg::dmtr_tune_s tune_in,
  input  wire dmtr_pkg::dmtr_tune_s tune_rst_in,
  // held tuning
  output dmtr_pkg::dmtr_tune_s      tune_out
);

  // the modulators must never see a setting change mid-sample, so the
  // register value is copied only on the sample boundary
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tune_out <= tune_rst_in;
    end else if (sample_strobe_in) begin
      tune_out <= tune_in;
    end
  end

endmodule : dmtr_tune_hold

// File: rtl/dmtr_regs.sv
// dmtr_regs: tuning register bank for the delta-sigma modulators.
// assumes the control port delivers decoded single-cycle read and write
// strobes on clk_sys_in; the modulators sample the tuning outputs.
`timescale 1ns/1ns
module dmtr_regs (
  // clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_n_in,
  // register access from the control port
  input  wire dmtr_pkg::dmtr_wr_s          wr_in,
  input  wire logic                        rd_en_in,
  input  wire logic [dmtr_pkg::ADDR_W-1:0] rd_addr_in,
  output logic      [dmtr_pkg::DATA_W-1:0] rdata_out,
  output logic                             rd_hit_out,
  // modulator sample boundary
  input  wire logic                        sample_strobe_in,
  // tuning to the modulators and the supply detector
  output dmtr_pkg::dmtr_tune_s             tune_out
);

  localparam logic [dmtr_pkg::ADDR_W-1:0] OFS [dmtr_pkg::NUM_REGS] = '{
    dmtr_pkg::PRI_COEFF_ZERO_OFS, dmtr_pkg::PRI_LOOP_GAIN_OFS,
    dmtr_pkg::SEC_COEFF_ZERO_OFS, dmtr_pkg::SEC_LOOP_GAIN_OFS,
    dmtr_pkg::NEG_HYST_OFS};
  localparam logic [dmtr_pkg::DATA_W-1:0] RST [dmtr_pkg::NUM_REGS] = '{
    dmtr_pkg::PRI_COEFF_ZERO_RST, dmtr_pkg::PRI_LOOP_GAIN_RST,
    dmtr_pkg::SEC_COEFF_ZERO_RST, dmtr_pkg::SEC_LOOP_GAIN_RST,
    dmtr_pkg::NEG_HYST_RST};

  localparam int unsigned IDX_PCZ = 0;
  localparam int unsigned IDX_PLG = 1;
  localparam int unsigned IDX_SCZ = 2;
  localparam int unsigned IDX_SLG = 3;
  localparam int unsigned IDX_HYS = 4;

  logic [dmtr_pkg::DATA_W-1:0] regs [dmtr_pkg::NUM_REGS];
  dmtr_pkg::dmtr_tune_s        live_tune;
  dmtr_pkg::dmtr_tune_s        rst_tune;
  logic [dmtr_pkg::DATA_W-1:0] next_rdata;
  logic                        next_hit;

  // one-hot decode, used for both write and read
  function automatic logic [dmtr_pkg::NUM_REGS-1:0] decode(
    input logic [dmtr_pkg::ADDR_W-1:0] a);
    logic [dmtr_pkg::NUM_REGS-1:0] sel;
    sel = '0;
    for (int i = 0; i < dmtr_pkg::NUM_REGS; i++) begin
      sel[i] = (a == OFS[i]);
    end
    return sel;
  endfunction : decode

  // unpack coefficient-zero and gain registers into one modulator view
  function automatic dmtr_pkg::dmtr_mod_s unpack(
    input logic [dmtr_pkg::DATA_W-1:0] cz,
    input logic [dmtr_pkg::DATA_W-1:0] lg,
    input logic                        left);
    dmtr_pkg::dmtr_mod_s m;
    if (left) begin
      m.a0_zero    = cz[dmtr_pkg::LEFT_A0_BIT];
      m.b1_zero    = cz[dmtr_pkg::LEFT_B1_BIT];
      m.b2_zero    = cz[dmtr_pkg::LEFT_B2_BIT];
      m.b3_zero    = cz[dmtr_pkg::LEFT_B3_BIT];
      m.loop_gain  = lg[dmtr_pkg::LEFT_GAIN_BIT];
      m.upper_bits = lg[dmtr_pkg::LEFT_UPPER_BIT];
    end else begin
      m.a0_zero    = cz[dmtr_pkg::RIGHT_A0_BIT];
      m.b1_zero    = cz[dmtr_pkg::RIGHT_B1_BIT];
      m.b2_zero    = cz[dmtr_pkg::RIGHT_B2_BIT];
      m.b3_zero    = cz[dmtr_pkg::RIGHT_B3_BIT];
      m.loop_gain  = lg[dmtr_pkg::RIGHT_GAIN_BIT];
      m.upper_bits = lg[dmtr_pkg::RIGHT_UPPER_BIT];
    end
    return m;
  endfunction : unpack

  logic [dmtr_pkg::NUM_REGS-1:0] wr_sel;
  assign wr_sel = wr_in.wr_en ? decode(wr_in.addr) : '0;

  // all five registers are plain read/write with a reset value
  genvar g;
  generate
    for (g = 0; g < dmtr_pkg::NUM_REGS; g++) begin : g_reg
      dmtr_reg8 #(
        .RST_VAL (RST[g])
      ) u_reg (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .wr_sel_in  (wr_sel[g]),
        .wdata_in   (wr_in.wdata),
        .q_out      (regs[g])
      );
    end
  endgenerate

  // primary modulators: coefficient zero and loop control
  assign live_tune.left_pri  = unpack(regs[IDX_PCZ], regs[IDX_PLG], 1'b1);
  assign live_tune.right_pri = unpack(regs[IDX_PCZ], regs[IDX_PLG], 1'b0);
  // secondary modulators
  assign live_tune.left_sec  = unpack(regs[IDX_SCZ], regs[IDX_SLG], 1'b1);
  assign live_tune.right_sec = unpack(regs[IDX_SCZ], regs[IDX_SLG], 1'b0);
  assign live_tune.neg_detect_hysteresis =
    regs[IDX_HYS][dmtr_pkg::HYST_MSB:dmtr_pkg::HYST_LSB];

  // the held copy resets to the same values as the registers
  assign rst_tune.left_pri  = unpack(dmtr_pkg::PRI_COEFF_ZERO_RST,
                                     dmtr_pkg::PRI_LOOP_GAIN_RST, 1'b1);
  assign rst_tune.right_pri = unpack(dmtr_pkg::PRI_COEFF_ZERO_RST,
                                     dmtr_pkg::PRI_LOOP_GAIN_RST, 1'b0);
  assign rst_tune.left_sec  = unpack(dmtr_pkg::SEC_COEFF_ZERO_RST,
                                     dmtr_pkg::SEC_LOOP_GAIN_RST, 1'b1);
  assign rst_tune.right_sec = unpack(dmtr_pkg::SEC_COEFF_ZERO_RST,
                                     dmtr_pkg::SEC_LOOP_GAIN_RST, 1'b0);
  assign rst_tune.neg_detect_hysteresis =
    dmtr_pkg::NEG_HYST_RST[dmtr_pkg::HYST_MSB:dmtr_pkg::HYST_LSB];

  dmtr_tune_hold u_hold (
    .clk_sys_in       (clk_sys_in),
    .rst_n_in         (rst_n_in),
    .sample_strobe_in (sample_strobe_in),
    .tune_in          (live_tune),
    .tune_rst_in      (rst_tune),
    .tune_out         (tune_out)
  );

  // read mux; an unmapped offset reads zero and drops the hit flag
  always_comb begin
    logic [dmtr_pkg::NUM_REGS-1:0] rsel;
    rsel       = decode(rd_addr_in);
    next_rdata = dmtr_pkg::UNMAPPED_READ;
    next_hit   = 1'b0;
    for (int i = 0; i < dmtr_pkg::NUM_REGS; i++) begin
      if (rsel[i]) begin
        next_rdata = regs[i];
        next_hit   = 1'b1;
      end
    end
  end

  // read data is registered and held until the next read
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_out  <= dmtr_pkg::UNMAPPED_READ;
      rd_hit_out <= 1'b0;
    end else if (rd_en_in) begin
      rdata_out  <= next_rdata;
      rd_hit_out <= next_hit;
    end
  end

endmodule : dmtr_regs

// File: verification/dmtr_regs_sva.sv
// dmtr_regs_sva: port assertions for the tuning register bank.
// assumes one clock and a synchronous active-low reset; bound onto dmtr_regs.
`timescale 1ns/1ns
module dmtr_regs_sva (
  // clock and reset
  input wire logic                        clk_sys_in,
  input wire logic                        rst_n_in,
  // register access
  input wire dmtr_pkg::dmtr_wr_s          wr_in,
  input wire logic                        rd_en_in,
  input wire logic [dmtr_pkg::ADDR_W-1:0] rd_addr_in,
  input wire logic [dmtr_pkg::DATA_W-1:0] rdata_out,
  input wire logic                        rd_hit_out,
  // tuning
  input wire logic                        sample_strobe_in,
  input wire dmtr_pkg::dmtr_tune_s        tune_out
);
  // write data two edges back, for the write-then-use sequences
  logic [15:0] wd_d;
  always_ff @(posedge clk_sys_in) begin
    wd_d <= {wd_d[7:0], wr_in.wdata};
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence wr_strobe(logic [7:0] a);
    wr_in.wr_en && wr_in.addr == a ##1 sample_strobe_in && !wr_in.wr_en;
  endsequence
  sequence wr_read;
    wr_in.wr_en && wr_in.addr inside {[8'h12:8'h16]} ##1
      rd_en_in && rd_addr_in == $past(wr_in.addr) && !wr_in.wr_en;
  endsequence
  tune_hold_a: assert property (!sample_strobe_in |=> $stable(tune_out))
    else $error("tune moved without strobe");
  rdata_hold_a: assert property (!rd_en_in |=> $stable(rdata_out) && $stable(rd_hit_out))
    else $error("read outputs moved without read");
  map_hit_a: assert property (rd_en_in && rd_addr_in inside {[8'h12:8'h16]} |=> rd_hit_out)
    else $error("mapped read missed");
  unmapped_rd_a: assert property (rd_en_in && !(rd_addr_in inside {[8'h12:8'h16]})
    |=> !rd_hit_out && rdata_out == 8'h00) else $error("unmapped read not zero");
  read_back_a: assert property (wr_read |=> rdata_out == wd_d[15:8])
    else $error("read back differs");
  pri_coeff_a: assert property (wr_strobe(8'h12) |=>
    {tune_out.left_pri[5:2], tune_out.right_pri[5:2]} == wd_d[15:8]) else $error("pri coeff");
  pri_gain_a: assert property (wr_strobe(8'h13) |=>
    {tune_out.left_pri[1:0], tune_out.right_pri[1:0]} == {wd_d[15], wd_d[13], wd_d[11], wd_d[9]})
    else $error("pri gain");
  sec_coeff_a: assert property (wr_strobe(8'h14) |=>
    {tune_out.left_sec[5:2], tune_out.right_sec[5:2]} == wd_d[15:8]) else $error("sec coeff");
  sec_gain_a: assert property (wr_strobe(8'h15) |=>
    {tune_out.left_sec[1:0], tune_out.right_sec[1:0]} == {wd_d[15], wd_d[13], wd_d[11], wd_d[9]})
    else $error("sec gain");
  hyst_value_a: assert property (wr_strobe(8'h16) |=>
    tune_out.neg_detect_hysteresis == wd_d[9:8]) else $error("hysteresis");
endmodule : dmtr_regs_sva

bind dmtr_regs dmtr_regs_sva chk_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .wr_in(wr_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rdata_out(rdata_out),
  .rd_hit_out(rd_hit_out), .sample_strobe_in(sample_strobe_in), .tune_out(tune_out));

// File: verification/tb.sv
// tb: directed register and tuning tests for dmtr_regs.
// assumes one-cycle control-port and sample strobes; inputs move on falling edges.
`timescale 1ns/1ns
module tb;
  logic                 clk_sys_in;
  logic                 rst_n_in;
  dmtr_pkg::dmtr_wr_s   wr_in;
  logic                 rd_en_in;
  logic [7:0]           rd_addr_in;
  logic [7:0]           rdata_out;
  logic                 rd_hit_out;
  logic                 sample_strobe_in;
  dmtr_pkg::dmtr_tune_s tune_out;
  logic [7:0]           shd [5];
  logic [7:0]           bad_ofs [5] = '{8'h11, 8'h17, 8'h92, 8'h00, 8'hff};
  logic [25:0]          last_tune;
  int                   miscompares;
  int                   samples_checked;

  dmtr_regs dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wr_in(wr_in),
    .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rdata_out(rdata_out),
    .rd_hit_out(rd_hit_out), .sample_strobe_in(sample_strobe_in), .tune_out(tune_out));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [25:0] exp_tune();
    return {shd[0][7:4], shd[1][7], shd[1][5], shd[0][3:0], shd[1][3], shd[1][1],
      shd[2][7:4], shd[3][7], shd[3][5], shd[2][3:0], shd[3][3], shd[3][1], shd[4][1:0]};
  endfunction : exp_tune

  task automatic cmp_rd(input logic [7:0] d, input logic h);
    samples_checked++;
    if ({rd_hit_out, rdata_out} !== {h, d}) begin
      miscompares++;
      $display("CHECK FAILED %0t read %h exp %h", $time, {rd_hit_out, rdata_out}, {h, d});
    end
  endtask : cmp_rd

  task automatic cmp_tune(input logic [25:0] e);
    samples_checked++;
    if (tune_out !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t tune %h exp %h", $time, tune_out, e);
    end
  endtask : cmp_tune

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    wr_in = {1'b1, a, d};
    @(negedge clk_sys_in);
    wr_in.wr_en = 1'b0;
    if (a inside {[8'h12:8'h16]}) shd[a - 8'h12] = d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    @(negedge clk_sys_in);
    rd_en_in = 1'b1;
    rd_addr_in = a;
    @(negedge clk_sys_in);
    rd_en_in = 1'b0;
    cmp_rd(d, h);
  endtask : rd

  // write, then read the same offset on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    wr_in = {1'b1, a, d};
    @(negedge clk_sys_in);
    wr_in.wr_en = 1'b0;
    rd_en_in = 1'b1;
    rd_addr_in = a;
    @(negedge clk_sys_in);
    rd_en_in = 1'b0;
    shd[a - 8'h12] = d;
    cmp_rd(d, 1'b1);
  endtask : wr_rd

  // called on the falling edge that ends a write, so the strobe lands on the
  // edge right after the write edge, the tightest spacing the bank allows
  task automatic strobe();
    sample_strobe_in = 1'b1;
    @(negedge clk_sys_in);
    sample_strobe_in = 1'b0;
    last_tune = exp_tune();
  endtask : strobe

  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (8) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    shd = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    last_tune = exp_tune();
  endtask : do_reset

  task automatic check_all();
    for (int i = 0; i < 5; i++) rd(8'h12 + i[7:0], shd[i], 1'b1);
    cmp_tune(last_tune);
  endtask : check_all

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    // the tests take about 294 cycles; this allows nearly seven times that
    #100000;
    miscompares++;
    conclude();
  end

  initial begin
    wr_in = '0;
    rd_en_in = 1'b0;
    rd_addr_in = 8'h00;
    sample_strobe_in = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    do_reset();
    check_all();
    // unmapped offsets either side of the bank must not alias into it
    foreach (bad_ofs[i]) begin
      wr(bad_ofs[i], 8'hff);
      rd(bad_ofs[i], 8'h00, 1'b0);
    end
    check_all();
    // one set bit walks through every field, tune must wait for the strobe
    for (int r = 0; r < 5; r++) begin
      for (int b = 0; b < 8; b++) begin
        wr(8'h12 + r[7:0], 8'h01 << b);
        cmp_tune(last_tune);
        strobe();
        cmp_tune(last_tune);
        rd(8'h12 + r[7:0], shd[r], 1'b1);
      end
    end
    // write and read of one offset in the same cycle returns the old value
    @(negedge clk_sys_in);
    wr_in = {1'b1, 8'h14, 8'h3c};
    rd_en_in = 1'b1;
    rd_addr_in = 8'h14;
    @(negedge clk_sys_in);
    wr_in.wr_en = 1'b0;
    rd_en_in = 1'b0;
    cmp_rd(shd[2], 1'b1);
    shd[2] = 8'h3c;
    for (int i = 0; i < 5; i++) wr_rd(8'h12 + i[7:0], 8'ha5 ^ i[7:0]);
    strobe();
    check_all();
    do_reset();
    check_all();
    conclude();
  end
endmodule : tb
